// ---- src/vcss_defs.vh ----
// Constants for the voltage-code and soft-start sequencer
`ifndef VCSS_DEFS_VH
`define VCSS_DEFS_VH

// Register byte offsets
`define VCSS_ADDR_CTRL     4'h0
`define VCSS_ADDR_STATUS   4'h4
`define VCSS_ADDR_REF      4'h8
`define VCSS_ADDR_SSCNT    4'hC

// Control register reset value and field
`define VCSS_CTRL_RESET    1'h0
`define VCSS_CTRL_HOLD_BIT 0

// AXI responses
`define VCSS_RESP_OKAY     2'h0
`define VCSS_RESP_SLVERR   2'h2

// Sequencer states
`define VCSS_ST_SHUTDOWN   2'h0
`define VCSS_ST_SOFTSTART  2'h1
`define VCSS_ST_RUN        2'h2

// Voltage code decode: three codes, then three values in millivolts
`define VCSS_CODE_OFF      5'h1F
`define VCSS_CODE_RESET    5'h1F
`define VCSS_TARGET_RESET  5'h00
`define VCSS_TOP_MV        12'h60E
`define VCSS_STEP_MV       12'h019
`define VCSS_LOW_OFFSET_MV 12'h15E

// Soft-start ramp: 140 percent is 7/5, span is 2^11 ticks
`define VCSS_RAMP_NUM      3'h7
`define VCSS_RAMP_DEN      27'h0002800
`define VCSS_SS_LAST       11'h7FF
`define VCSS_SS_ZERO       11'h000

`endif

// ---- src/vcss_top.v ----
// Voltage-code tracking, soft-start and output-ok sequencer with AXI4-Lite registers
`timescale 1ns/1ns
// Functional notes
// R1: Sample five code bits at cycle start
// R2: Accept new code after one stable cycle
// R3: One 25mV step every two cycles
// R4: PWM outputs high impedance in shutdown
// R5: Enable ignored until supply detected
// R6: Shutdown until enable comparator above threshold
// R7: Grounded select pin stops oscillator, shutdown
// R8: All-ones code means shutdown, else start
// R9: All conditions true starts soft-start immediately
// R10: Eleven-bit counter, one count per tick
// R11: Ramp voltage up to 140%, current down
// R12: Regulate to lower of reference, ramp
// R13: Flag low in shutdown, rises past threshold
// R14: Flag drops on disable or fault
// R15: Threshold is diff plus 350mV against reference
// R16: Flag rises only without overcurrent fault
// R17: Below threshold drops flag, keeps switching
// R18: Disabled flag held until output decays
// R19: Code zero 1.550V, minus 25mV per count
// R20: Step both ways, restart validation on change
// R21: Lost condition resets soft-start counter fully
`include "vcss_defs.vh"

module vcss_top #(
  parameter SS_BITS = 11,  // Soft-start counter width
  parameter MV_BITS = 12   // Millivolt value width
) (
  // Clock and reset
  input  wire               CORE_CLK_IN,
  input  wire               ARST_N_IN,
  // AXI4-Lite write address and data
  input  wire               S_AXI_AWVALID_IN,
  output wire               S_AXI_AWREADY_OUT,
  input  wire [3:0]         S_AXI_AWADDR_IN,
  input  wire               S_AXI_WVALID_IN,
  output wire               S_AXI_WREADY_OUT,
  input  wire [31:0]        S_AXI_WDATA_IN,
  input  wire [3:0]         S_AXI_WSTRB_IN,
  // AXI4-Lite write response
  output reg                S_AXI_BVALID_OUT,
  input  wire               S_AXI_BREADY_IN,
  output reg  [1:0]         S_AXI_BRESP_OUT,
  // AXI4-Lite read
  input  wire               S_AXI_ARVALID_IN,
  output wire               S_AXI_ARREADY_OUT,
  input  wire [3:0]         S_AXI_ARADDR_IN,
  output reg                S_AXI_RVALID_OUT,
  input  wire               S_AXI_RREADY_IN,
  output reg  [31:0]        S_AXI_RDATA_OUT,
  output reg  [1:0]         S_AXI_RRESP_OUT,
  // Converter inputs
  input  wire               PHASE_TICK_IN,
  input  wire [4:0]         VOLTAGE_CODE_IN,
  input  wire               SUPPLY_READY_IN,
  input  wire               ENABLE_ABOVE_IN,
  input  wire               FREQ_SEL_SHUTDOWN_PIN_IN,
  input  wire               OVERCURRENT_FAULT_IN,
  input  wire [MV_BITS-1:0] SENSED_OUTPUT_DIFF_IN,
  // Converter outputs
  output reg  [4:0]         REF_CODE_OUT,
  output reg  [MV_BITS-1:0] REG_TARGET_MV_OUT,
  output reg  [MV_BITS-1:0] SOFTSTART_RAMP_VOLTAGE_OUT,
  output reg  [SS_BITS-1:0] SOFTSTART_RAMP_CURRENT_OUT,
  output reg                PWM_OE_OUT,
  output reg                OSC_RUN_OUT,
  output wire               OUTPUT_OK_FLAG_OUT,
  output reg                OUTPUT_OK_FLAG_OE_OUT
);

  // Sequencer state
  reg  [1:0]         state;         // Shutdown, soft-start or run
  reg  [1:0]         next_state;    // Combinational successor
  reg  [SS_BITS-1:0] ss_cnt;        // Soft-start progress
  reg                ok_flag;       // Output-ok level seen outside

  // Code tracking
  reg  [4:0]         code_seen;     // Code sampled at last cycle start
  reg  [4:0]         code_pend;     // Candidate awaiting validation
  reg                pend;          // Validation in progress
  reg  [4:0]         code_target;   // Accepted code
  reg                step_phase;    // Halves the stepping rate

  // Software control
  reg                sw_hold;       // Software hold in shutdown

  // AXI write capture
  reg                aw_full;       // Write address captured
  reg  [3:0]         aw_addr;       // Captured write address
  reg                w_full;        // Write data captured
  reg  [31:0]        w_data;        // Captured write data
  reg  [3:0]         w_strb;        // Captured byte enables

  // Derived values
  wire               conds_ok;      // All start conditions together
  wire [MV_BITS-1:0] ref_mv;        // Reference setting in millivolts
  wire [MV_BITS-1:0] low_thresh;    // Reference less the window offset
  wire               above_low;     // Output above the low threshold
  wire [26:0]        ramp_prod;     // Reference times 7 times count
  wire [26:0]        ramp_quot;     // Full-width ramp quotient
  wire [MV_BITS-1:0] ramp_mv;       // Ramp voltage in millivolts
  wire               wr_go;         // Both write halves present
  reg  [MV_BITS-1:0] code_mv_tmp;   // Scratch for decode

  // Decode: top value less one step per count; all-ones unused here [R19]
  always @* begin
    code_mv_tmp = `VCSS_STEP_MV * {{(MV_BITS-5){1'b0}}, REF_CODE_OUT};
  end
  assign ref_mv = `VCSS_TOP_MV - code_mv_tmp; // [R19]

  // Offset lets the low threshold follow the selected code [R15]
  // Subtracting from the reference instead of adding to the sensed value
  // keeps a large sensed reading from wrapping; the lowest reference is
  // well above the offset, so the difference cannot go negative
  assign low_thresh = ref_mv - `VCSS_LOW_OFFSET_MV; // [R15]
  assign above_low  = (SENSED_OUTPUT_DIFF_IN > low_thresh); // [R15]

  // Supply gates switching, not the oscillator; enable only counts once supply is up [R5] [R6]
  // Grounded select pin and all-ones code each force shutdown [R7] [R8]
  // Software hold acts as one more lost condition
  assign conds_ok = SUPPLY_READY_IN & ENABLE_ABOVE_IN &
                    FREQ_SEL_SHUTDOWN_PIN_IN & ~sw_hold &
                    (code_seen != `VCSS_CODE_OFF); // [R5] [R6] [R7] [R8] [R9]

  // Ramp is 7/5 of reference scaled by count over 2048 [R11]
  // The product is kept wide; the quotient never exceeds 7/5 of the
  // top reference, so the low bits hold the whole result
  assign ramp_prod = {15'h0000, ref_mv} * {24'h000000, `VCSS_RAMP_NUM} *
                     {16'h0000, ss_cnt};
  assign ramp_quot = ramp_prod / `VCSS_RAMP_DEN; // [R11]
  assign ramp_mv   = ramp_quot[MV_BITS-1:0]; // [R11]

  // State successor
  // Soft-start moves to run only on the tick that ends count 2047, so the
  // interval spans exactly 2048 phase clock periods
  always @* begin
    next_state = state;
    case (state)
      `VCSS_ST_SHUTDOWN: begin
        // No delay once every condition holds [R9]
        if (conds_ok) begin
          next_state = `VCSS_ST_SOFTSTART; // [R9]
        end
      end
      `VCSS_ST_SOFTSTART: begin
        if (!conds_ok) begin
          next_state = `VCSS_ST_SHUTDOWN; // [R21]
        end else if (PHASE_TICK_IN && ss_cnt == `VCSS_SS_LAST) begin
          next_state = `VCSS_ST_RUN; // [R10]
        end
      end
      `VCSS_ST_RUN: begin
        if (!conds_ok) begin
          next_state = `VCSS_ST_SHUTDOWN; // [R21]
        end
      end
      default: begin
        next_state = `VCSS_ST_SHUTDOWN;
      end
    endcase
  end

  // Sequencer registers and soft-start counter
  // The counter is cleared whenever soft-start is not the next state, so
  // every restart replays the whole interval from zero
  always @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      state  <= `VCSS_ST_SHUTDOWN;
      ss_cnt <= `VCSS_SS_ZERO;
    end else begin
      state <= next_state;
      if (next_state != `VCSS_ST_SOFTSTART) begin
        // Any lost condition forces a fresh full sequence later [R21]
        ss_cnt <= `VCSS_SS_ZERO; // [R21]
      end else if (state == `VCSS_ST_SOFTSTART && PHASE_TICK_IN) begin
        ss_cnt <= ss_cnt + 1'b1; // [R10]
      end
    end
  end

  // Code sampling, validation and stepping; only at cycle starts [R1]
  // Between ticks the code pins are not looked at, so a glitch that
  // settles before the next tick never disturbs the reference
  always @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      code_seen    <= `VCSS_CODE_RESET;
      code_pend    <= `VCSS_CODE_RESET;
      pend         <= 1'b0;
      code_target  <= `VCSS_TARGET_RESET;
      step_phase   <= 1'b0;
      REF_CODE_OUT <= `VCSS_TARGET_RESET;
    end else if (PHASE_TICK_IN) begin
      code_seen <= VOLTAGE_CODE_IN; // [R1]
      if (VOLTAGE_CODE_IN != code_seen) begin
        // A further change restarts the stable-cycle wait [R20]
        pend      <= 1'b1; // [R2] [R20]
        code_pend <= VOLTAGE_CODE_IN;
      end else if (pend) begin
        // Unchanged for one whole cycle: accept unless it is the off code
        pend <= 1'b0; // [R2]
        if (code_pend != `VCSS_CODE_OFF) begin
          code_target <= code_pend; // [R2]
        end
      end
      if (state != `VCSS_ST_RUN) begin
        // Outside run the reference jumps; soft-start ramps the output
        REF_CODE_OUT <= code_target;
        step_phase   <= 1'b0;
      end else if (REF_CODE_OUT != code_target) begin
        step_phase <= ~step_phase; // [R3]
        if (step_phase) begin
          // Lower code means higher voltage; step either way [R20]
          if (code_target < REF_CODE_OUT) begin
            REF_CODE_OUT <= REF_CODE_OUT - 1'b1; // [R3] [R20]
          end else begin
            REF_CODE_OUT <= REF_CODE_OUT + 1'b1; // [R3] [R20]
          end
        end
      end else begin
        step_phase <= 1'b0;
      end
    end
  end

  // Output-ok flag: low drive is the only drive of the open-drain pin
  // The flag lags the compare by one clock and its pin enable by two; the
  // analog side moves far slower, so the delay is harmless
  always @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      ok_flag <= 1'b0;
    end else begin
      case (state)
        `VCSS_ST_SHUTDOWN: begin
          // Once disabled, hold high until output decays below threshold [R13] [R18]
          ok_flag <= ok_flag & above_low; // [R13] [R14] [R18]
        end
        `VCSS_ST_SOFTSTART: begin
          ok_flag <= above_low & ~OVERCURRENT_FAULT_IN; // [R13] [R16]
        end
        `VCSS_ST_RUN: begin
          // Undervoltage only flags; switching continues [R17]
          ok_flag <= above_low & ~OVERCURRENT_FAULT_IN; // [R14] [R17]
        end
        default: begin
          ok_flag <= 1'b0;
        end
      endcase
    end
  end
  assign OUTPUT_OK_FLAG_OUT = 1'b0;

  // Converter-facing outputs, all from flip-flops
  // PWM enable follows the next state so the drivers are released on the
  // same edge that the sequencer enters shutdown
  always @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      PWM_OE_OUT                 <= 1'b0;
      OSC_RUN_OUT                <= 1'b0;
      OUTPUT_OK_FLAG_OE_OUT      <= 1'b1;
      SOFTSTART_RAMP_VOLTAGE_OUT <= {MV_BITS{1'b0}};
      SOFTSTART_RAMP_CURRENT_OUT <= `VCSS_SS_LAST;
      REG_TARGET_MV_OUT          <= {MV_BITS{1'b0}};
    end else begin
      // PWM released to high impedance in shutdown [R4]
      PWM_OE_OUT  <= (next_state != `VCSS_ST_SHUTDOWN); // [R4]
      // Oscillator stops while the select pin is grounded [R7]
      OSC_RUN_OUT <= FREQ_SEL_SHUTDOWN_PIN_IN; // [R7]
      OUTPUT_OK_FLAG_OE_OUT <= ~ok_flag; // [R13]
      if (state == `VCSS_ST_SOFTSTART) begin
        SOFTSTART_RAMP_VOLTAGE_OUT <= ramp_mv; // [R11]
        SOFTSTART_RAMP_CURRENT_OUT <= `VCSS_SS_LAST - ss_cnt; // [R11]
        // Lower of reference and ramp [R12]
        REG_TARGET_MV_OUT <= (ramp_mv < ref_mv) ? ramp_mv : ref_mv; // [R12]
      end else if (state == `VCSS_ST_RUN) begin
        SOFTSTART_RAMP_VOLTAGE_OUT <= ramp_mv;
        SOFTSTART_RAMP_CURRENT_OUT <= `VCSS_SS_ZERO;
        REG_TARGET_MV_OUT          <= ref_mv;
      end else begin
        SOFTSTART_RAMP_VOLTAGE_OUT <= {MV_BITS{1'b0}};
        SOFTSTART_RAMP_CURRENT_OUT <= `VCSS_SS_LAST;
        REG_TARGET_MV_OUT          <= {MV_BITS{1'b0}};
      end
    end
  end

  // AXI write channels accepted in either order, one write at a time
  assign S_AXI_AWREADY_OUT = ~aw_full & ~S_AXI_BVALID_OUT;
  assign S_AXI_WREADY_OUT  = ~w_full & ~S_AXI_BVALID_OUT;
  assign wr_go             = aw_full & w_full;

  // Write capture, register update and response
  // Only the control word is writable; the rest answer with an error
  always @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      aw_full          <= 1'b0;
      aw_addr          <= 4'h0;
      w_full           <= 1'b0;
      w_data           <= 32'h00000000;
      w_strb           <= 4'h0;
      S_AXI_BVALID_OUT <= 1'b0;
      S_AXI_BRESP_OUT  <= `VCSS_RESP_OKAY;
      sw_hold          <= `VCSS_CTRL_RESET;
    end else begin
      if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT) begin
        aw_full <= 1'b1;
        aw_addr <= S_AXI_AWADDR_IN;
      end
      if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT) begin
        w_full <= 1'b1;
        w_data <= S_AXI_WDATA_IN;
        w_strb <= S_AXI_WSTRB_IN;
      end
      if (wr_go) begin
        aw_full          <= 1'b0;
        w_full           <= 1'b0;
        S_AXI_BVALID_OUT <= 1'b1;
        if ({aw_addr[3:2], 2'b00} == `VCSS_ADDR_CTRL) begin
          // Only lane 0 carries a writable bit
          if (w_strb[0]) begin
            sw_hold <= w_data[`VCSS_CTRL_HOLD_BIT];
          end
          S_AXI_BRESP_OUT <= `VCSS_RESP_OKAY;
        end else begin
          // Status, reference and count registers are read only and answer with an error
          S_AXI_BRESP_OUT <= `VCSS_RESP_SLVERR;
        end
      end else if (S_AXI_BVALID_OUT && S_AXI_BREADY_IN) begin
        S_AXI_BVALID_OUT <= 1'b0;
      end
    end
  end

  // AXI read: one outstanding read, answer one cycle after the address
  // Read data is registered, so status shows the cycle of the address
  assign S_AXI_ARREADY_OUT = ~S_AXI_RVALID_OUT;

  // Read data mux and response
  always @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      S_AXI_RVALID_OUT <= 1'b0;
      S_AXI_RDATA_OUT  <= 32'h00000000;
      S_AXI_RRESP_OUT  <= `VCSS_RESP_OKAY;
    end else if (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT) begin
      S_AXI_RVALID_OUT <= 1'b1;
      S_AXI_RRESP_OUT  <= `VCSS_RESP_OKAY;
      case ({S_AXI_ARADDR_IN[3:2], 2'b00})
        `VCSS_ADDR_CTRL: begin
          S_AXI_RDATA_OUT <= {31'h00000000, sw_hold};
        end
        `VCSS_ADDR_STATUS: begin
          // State, flag, pending, above threshold, condition summary
          S_AXI_RDATA_OUT <= {26'h0000000, conds_ok, above_low, pend,
                              ok_flag, state};
        end
        `VCSS_ADDR_REF: begin
          S_AXI_RDATA_OUT <= {11'h000, code_seen, 3'h0, code_target,
                              3'h0, REF_CODE_OUT};
        end
        `VCSS_ADDR_SSCNT: begin
          S_AXI_RDATA_OUT <= {21'h000000, ss_cnt};
        end
        default: begin
          S_AXI_RDATA_OUT <= 32'h00000000;
          S_AXI_RRESP_OUT <= `VCSS_RESP_SLVERR;
        end
      endcase
    end else if (S_AXI_RVALID_OUT && S_AXI_RREADY_IN) begin
      S_AXI_RVALID_OUT <= 1'b0;
    end
  end

endmodule // vcss_top

// ---- testbench/vcss_asserts.sv ----
// Port-level checker for the sequencer top
`timescale 1ns/1ns
module vcss_asserts #(
  parameter SS_BITS = 11,
  parameter MV_BITS = 12
) (
  input wire               CORE_CLK_IN,
  input wire               ARST_N_IN,
  input wire               PHASE_TICK_IN,
  input wire [4:0]         VOLTAGE_CODE_IN,
  input wire               SUPPLY_READY_IN,
  input wire               ENABLE_ABOVE_IN,
  input wire               FREQ_SEL_SHUTDOWN_PIN_IN,
  input wire               OVERCURRENT_FAULT_IN,
  input wire [MV_BITS-1:0] SENSED_OUTPUT_DIFF_IN,
  input wire [4:0]         REF_CODE_OUT,
  input wire [SS_BITS-1:0] SOFTSTART_RAMP_CURRENT_OUT,
  input wire               PWM_OE_OUT,
  input wire               OSC_RUN_OUT,
  input wire               OUTPUT_OK_FLAG_OE_OUT
);
  // Reference in mV and the offset under-voltage compare
  wire [13:0] ref_mv = 14'h060E - 14'h0019 * REF_CODE_OUT;
  wire        below_win = (SENSED_OUTPUT_DIFF_IN + 14'h015E) <= ref_mv;
  // PWM driven and ramp current gone: run, or soft-start at its last count
  wire        run    = PWM_OE_OUT && (SOFTSTART_RAMP_CURRENT_OUT == 0);

  default clocking @(posedge CORE_CLK_IN); endclocking
  default disable iff (!ARST_N_IN);

  a_supply_off: assert property (!SUPPLY_READY_IN |=> !PWM_OE_OUT)
    else $error("PWM driven without supply");
  a_enable_off: assert property (!ENABLE_ABOVE_IN |=> !PWM_OE_OUT)
    else $error("PWM driven while enable low");
  a_pin_off: assert property (!FREQ_SEL_SHUTDOWN_PIN_IN
    |=> !OSC_RUN_OUT && !PWM_OE_OUT)
    else $error("Oscillator or PWM active with pin grounded");
  a_code_off: assert property (PHASE_TICK_IN && VOLTAGE_CODE_IN == 5'h1F
    |=> ##1 !PWM_OE_OUT)
    else $error("All-ones code did not shut down");
  a_idle_ramp: assert property (!PWM_OE_OUT [*2] |-> SOFTSTART_RAMP_CURRENT_OUT == 11'h7FF)
    else $error("Ramp current not at full in shutdown");
  a_ref_step: assert property (run && $past(run) && $changed(REF_CODE_OUT)
    |-> 5'(REF_CODE_OUT - $past(REF_CODE_OUT)) inside {5'h01, 5'h1F})
    else $error("Reference moved by more than one step");
  a_step_gap: assert property (run && $changed(REF_CODE_OUT)
    |=> ($stable(REF_CODE_OUT) || !PWM_OE_OUT) [*3])
    else $error("Reference steps too close together");
  a_fault_flag: assert property ((PWM_OE_OUT && OVERCURRENT_FAULT_IN) [*2]
    |=> OUTPUT_OK_FLAG_OE_OUT)
    else $error("Flag released during overcurrent");
  a_low_drop: assert property ((PWM_OE_OUT && below_win && $stable(REF_CODE_OUT)) [*3]
    |=> OUTPUT_OK_FLAG_OE_OUT)
    else $error("Flag released below threshold");
  a_low_rise: assert property ((PWM_OE_OUT && !below_win && !OVERCURRENT_FAULT_IN
    && $stable(REF_CODE_OUT)) [*3] |=> !OUTPUT_OK_FLAG_OE_OUT)
    else $error("Flag held low above threshold");
  a_shut_flag: assert property ((!PWM_OE_OUT && OUTPUT_OK_FLAG_OE_OUT) [*3]
    |=> OUTPUT_OK_FLAG_OE_OUT)
    else $error("Flag released in shutdown");

  c_run: cover property ($rose(run));
  c_step: cover property (run && $changed(REF_CODE_OUT));
  c_flag: cover property (PWM_OE_OUT && $fell(OUTPUT_OK_FLAG_OE_OUT));
endmodule // vcss_asserts

// ---- testbench/vcss_proc_model.sv ----
// Processor side: phase tick source and voltage-code outputs
`timescale 1ns/1ns
module vcss_proc_model (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  // Control from the bench
  input  wire logic       tick_en_in,
  input  wire logic [4:0] req_code_in,
  // Pins toward the sequencer
  output logic            tick_out,
  output logic [4:0]      code_out
);
  // Tick every second cycle; code moves only just after a tick,
  // so a stalled tick source also freezes the code
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tick_out <= 1'b0;
      code_out <= 5'h1F; // No-load request until told otherwise
    end else begin
      tick_out <= tick_en_in && !tick_out;
      if (tick_out) code_out <= req_code_in;
    end
  end
endmodule // vcss_proc_model

// ---- testbench/vcss_top_test.sv ----
// Self-checking bench for the sequencer top
`timescale 1ns/1ns
bind vcss_top vcss_asserts #(.SS_BITS(SS_BITS), .MV_BITS(MV_BITS)) chk_u (
  .CORE_CLK_IN(CORE_CLK_IN), .ARST_N_IN(ARST_N_IN), .PHASE_TICK_IN(PHASE_TICK_IN),
  .VOLTAGE_CODE_IN(VOLTAGE_CODE_IN), .SUPPLY_READY_IN(SUPPLY_READY_IN),
  .ENABLE_ABOVE_IN(ENABLE_ABOVE_IN), .FREQ_SEL_SHUTDOWN_PIN_IN(FREQ_SEL_SHUTDOWN_PIN_IN),
  .OVERCURRENT_FAULT_IN(OVERCURRENT_FAULT_IN), .SENSED_OUTPUT_DIFF_IN(SENSED_OUTPUT_DIFF_IN),
  .REF_CODE_OUT(REF_CODE_OUT), .SOFTSTART_RAMP_CURRENT_OUT(SOFTSTART_RAMP_CURRENT_OUT),
  .PWM_OE_OUT(PWM_OE_OUT), .OSC_RUN_OUT(OSC_RUN_OUT),
  .OUTPUT_OK_FLAG_OE_OUT(OUTPUT_OK_FLAG_OE_OUT));
module vcss_top_test;
  logic        clk, rst_n, awv, wv, bre, arv, rre, sup, en, pin, fault, ten;
  logic [3:0]  awa, ara;
  logic [31:0] wd, d;
  logic [4:0]  req, old;
  logic [11:0] diff;
  logic [1:0]  r;
  wire         awr, wr_, bv, arr, rv, tick, pwm, osc, fl, fl_oe;
  wire  [1:0]  br, rr;
  wire  [31:0] rdat;
  wire  [4:0]  code, refc;
  wire  [11:0] tgt, rvm;
  wire  [10:0] ri;
  wire         ok_line = fl_oe ? fl : 1'b1; // Pull-up when released
  int failures = 0, tests_run = 0, cyc = 0, tk = 0, t0, n, rmv;
  int stp [4] = '{600, 1800, 2047, 2048};
  logic [4:0] vc [2] = '{5'h0C, 5'h0A};
  // Rows: supply, enable, pin, fault, above, then pwm, osc, line
  logic [7:0] rows [9] = '{8'hE6, 8'hEF, 8'hFE, 8'hEF, 8'hAB,
                           8'hA2, 8'h6A, 8'hC8, 8'hEF};

  vcss_top dut_u (.CORE_CLK_IN(clk), .ARST_N_IN(rst_n), .S_AXI_AWVALID_IN(awv),
    .S_AXI_AWREADY_OUT(awr), .S_AXI_AWADDR_IN(awa), .S_AXI_WVALID_IN(wv),
    .S_AXI_WREADY_OUT(wr_), .S_AXI_WDATA_IN(wd), .S_AXI_WSTRB_IN(4'hF),
    .S_AXI_BVALID_OUT(bv), .S_AXI_BREADY_IN(bre), .S_AXI_BRESP_OUT(br),
    .S_AXI_ARVALID_IN(arv), .S_AXI_ARREADY_OUT(arr), .S_AXI_ARADDR_IN(ara),
    .S_AXI_RVALID_OUT(rv), .S_AXI_RREADY_IN(rre), .S_AXI_RDATA_OUT(rdat),
    .S_AXI_RRESP_OUT(rr), .PHASE_TICK_IN(tick), .VOLTAGE_CODE_IN(code),
    .SUPPLY_READY_IN(sup), .ENABLE_ABOVE_IN(en), .FREQ_SEL_SHUTDOWN_PIN_IN(pin),
    .OVERCURRENT_FAULT_IN(fault), .SENSED_OUTPUT_DIFF_IN(diff), .REF_CODE_OUT(refc),
    .REG_TARGET_MV_OUT(tgt), .SOFTSTART_RAMP_VOLTAGE_OUT(rvm),
    .SOFTSTART_RAMP_CURRENT_OUT(ri), .PWM_OE_OUT(pwm), .OSC_RUN_OUT(osc),
    .OUTPUT_OK_FLAG_OUT(fl), .OUTPUT_OK_FLAG_OE_OUT(fl_oe));
  vcss_proc_model proc_u (.clk_in(clk), .rst_n_in(rst_n), .tick_en_in(ten),
    .req_code_in(req), .tick_out(tick), .code_out(code));

  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  // Ticks seen while driven: mirrors the soft-start count
  always @(posedge clk) begin
    if (!pwm) tk <= 0;
    else if (tick) tk <= tk + 1;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      finish_test();
    end
  end

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Write: both halves offered together, each released when taken
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    awa <= a; wd <= v; awv <= 1; wv <= 1; bre <= 1;
    do begin
      @(posedge clk);
      if (awv && awr) awv <= 0;
      if (wv && wr_) wv <= 0;
    end while (!bv);
    r = br;
    bre <= 0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    ara <= a; arv <= 1; rre <= 1;
    do begin
      @(posedge clk);
      if (arv && arr) arv <= 0;
    end while (!rv);
    d = rdat;
    r = rr;
    rre <= 0;
  endtask
  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    rst_n = 0; awv = 0; wv = 0; bre = 0; arv = 0; rre = 0; awa = 0; ara = 0;
    wd = 0; sup = 1; en = 1; pin = 1; fault = 0; ten = 1; req = 5'h1F; diff = 0;
    repeat (6) @(posedge clk);
    rst_n <= 1;
    repeat (20) @(posedge clk);
    chk("pwm_idle", pwm, 0);
    chk("ramp_i", ri, 11'h7FF);
    chk("line", ok_line, 0);
    rd(4'h0); chk("ctrl", d, 0);
    chk("rresp", r, 0);
    wr(4'h4, 1); chk("resp_ro", r, 2);
    @(posedge clk) req <= 5'h08;
    repeat (8) @(posedge clk);
    chk("pwm_on", pwm, 1);
    wr(4'h0, 1); chk("resp", r, 0);
    repeat (3) @(posedge clk);
    chk("pwm_hold", pwm, 0);
    rd(4'hC); chk("sscnt_clr", d, 0);
    wr(4'h0, 0);
    // Freeze the tick source at exact counts and inspect the ramp
    foreach (stp[i]) begin
      while (!(tick && tk == stp[i] - 1)) @(posedge clk);
      ten <= 0;
      repeat (4) @(posedge clk);
      rmv = 1350 * 7 * tk / 10240;
      chk("ramp_i", ri, (tk > 2047) ? 0 : 2047 - tk);
      rd(4'h4); chk("state", d[1:0], (tk > 2047) ? 2 : 1);
      chk("target", tgt, (rmv < 1350 && tk < 2048) ? rmv : 1350);
      if (tk < 2048) begin
        chk("ramp_v", rvm, rmv);
        rd(4'hC); chk("sscnt", d, tk);
      end
      ten <= 1;
    end
    // Code changes in run, up then down
    foreach (vc[i]) begin
      @(posedge clk) req <= vc[i];
      old = refc;
      n = (vc[i] > old) ? vc[i] - old : old - vc[i];
      while (code !== vc[i]) @(negedge clk);
      t0 = tk;
      while (refc === old) @(negedge clk);
      chk("first_step", tk - t0, 4);
      while (refc !== vc[i]) @(negedge clk);
      chk("last_step", tk - t0, 2 + 2 * n);
    end
    // Table of pin conditions and flag cases; reference now 1300 mV
    foreach (rows[i]) begin
      @(posedge clk);
      {sup, en, pin, fault} <= rows[i][7:4];
      diff <= 12'd950 + rows[i][3];
      repeat (4) @(posedge clk);
      chk("pwm", pwm, rows[i][2]);
      chk("osc", osc, rows[i][1]);
      chk("line", ok_line, rows[i][0]);
    end
    finish_test();
  end
endmodule // vcss_top_test
